//--- pkg/pmolp_pkg.sv
// Shared constants and types for the output limit and protection block
package pmolp_pkg;

   // Command codes decoded by this block
   localparam logic [7:0] CMD_FLOOR     = 8'h2B;
   localparam logic [7:0] CMD_FAULT_LIM = 8'h46;
   localparam logic [7:0] CMD_ACTION    = 8'h47;
   localparam logic [7:0] CMD_WARN_LIM  = 8'h4A;

   // Page selector values
   localparam logic [7:0] PAGE_A   = 8'h00;
   localparam logic [7:0] PAGE_B   = 8'h01;
   localparam logic [7:0] PAGE_ALL = 8'hFF;

   // Overcurrent action codes
   localparam logic [7:0] ACT_LATCH = 8'hC0;
   localparam logic [7:0] ACT_RETRY = 8'hFA;

   // Field layout of the floor word and of the linear limit words
   localparam int VID_W    = 8;
   localparam int MAN_W    = 11;
   localparam int MAN_MSB  = 10;
   localparam int EXP_LSB  = 11;
   localparam int EXP_MSB  = 15;
   localparam logic [4:0] LIMIT_EXP = 5'h00;

   // Reset values held until the nonvolatile defaults are loaded
   localparam logic [7:0]  FLOOR_RST  = 8'h00;
   localparam logic [10:0] LIMIT_RST  = 11'h000;
   localparam logic [7:0]  ACTION_RST = 8'hC0;
   localparam logic [7:0]  VOUT_RST   = 8'h00;

   // Enable source selection bits
   localparam int ONOFF_PIN_BIT = 0;
   localparam int ONOFF_OP_BIT  = 1;

   // Alert mask bit positions
   localparam int MASK_VMIN    = 0;
   localparam int MASK_OCWARN  = 1;
   localparam int MASK_OCFAULT = 2;

   // Restart delay after an overcurrent shutdown
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned RETRY_TIME_NS = 20000000;
   localparam int unsigned RETRY_CYCLES  = RETRY_TIME_NS / CLK_PERIOD_NS;

   // Per channel power state
   typedef enum logic [1:0]
   {
      CH_OFF     = 2'b00,
      CH_RUN     = 2'b01,
      CH_LATCHED = 2'b10,
      CH_RETRY   = 2'b11
   } pmolp_state_type;

endpackage

//--- hw/pmolp_channel.sv
// One channel of overcurrent detection with latch-off and retry handling
`timescale 1ns/10ps
module pmolp_channel
#(
   parameter int unsigned RetryCycles = pmolp_pkg::RETRY_CYCLES
)
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        enabled,
   input  wire logic [10:0] outputCurrent,
   input  wire logic [10:0] faultLimit,
   input  wire logic [10:0] warnLimit,
   input  wire logic [7:0]  actionCode,
   output logic             running,
   output logic             warnActive,
   output logic             faultEvent
);
   import pmolp_pkg::*;

   pmolp_state_type state_reg;
   logic [31:0]     retryCount_reg;
   logic            overFault;

   // Limits are signed mantissas with a unit step
   assign overFault  = $signed(outputCurrent) >= $signed(faultLimit);
   assign warnActive = $signed(outputCurrent) >= $signed(warnLimit);
   assign running    = (state_reg == CH_RUN);
   assign faultEvent = (state_reg == CH_RUN) && enabled && overFault;

   // Channel state; dropping the enable always leaves latch or retry
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= CH_OFF;
      end
      else if (!enabled)
      begin
         state_reg <= CH_OFF;
      end
      else
      begin
         case (state_reg)
            CH_OFF:
               state_reg <= CH_RUN;
            CH_RUN:
               if (overFault)
               begin
                  // Unknown codes latch off, the safe choice
                  if (actionCode == ACT_RETRY)
                     state_reg <= CH_RETRY;
                  else
                     state_reg <= CH_LATCHED;
               end
            CH_LATCHED:
               state_reg <= CH_LATCHED;
            CH_RETRY:
               if (retryCount_reg == 32'(RetryCycles - 1))
                  state_reg <= CH_RUN;
            default:
               state_reg <= CH_OFF;
         endcase
      end
   end

   // Restart delay counter, only counts while waiting to retry
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         retryCount_reg <= 32'h00000000;
      else if (state_reg == CH_RETRY && enabled)
         retryCount_reg <= retryCount_reg + 32'h00000001;
      else
         retryCount_reg <= 32'h00000000;
   end

endmodule

//--- hw/pmolp_top.sv
// Output voltage floor, overcurrent limits and status for two channels
`timescale 1ns/10ps

module pmolp_top
#(
   parameter int unsigned RetryCycles = pmolp_pkg::RETRY_CYCLES
)
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             cmdValid,
   input  wire logic             cmdWrite,
   input  wire logic             cmdIsWord,
   input  wire logic [7:0]       cmdCode,
   input  wire logic [7:0]       cmdPage,
   input  wire logic [15:0]      cmdWriteData,
   output logic      [15:0]      cmdReadData,
   output logic                  cmdReadValid,
   output logic                  cmdError,
   input  wire logic             clearFaults,
   input  wire logic             restoreDefaults,
   input  wire logic [1:0][7:0]  floorNvm,
   input  wire logic [7:0]       actionNvm,
   input  wire logic [1:0][10:0] maxCurrentCfg,
   input  wire logic [1:0][7:0]  voutRequest,
   input  wire logic [1:0]       voutRequestValid,
   output logic      [1:0][7:0]  voutCommand,
   input  wire logic [1:0][10:0] outputCurrent,
   input  wire logic [1:0]       channelEnablePins,
   input  wire logic [1:0]       operationOn,
   input  wire logic [1:0]       onOffConfig,
   input  wire logic [2:0]       alertMask,
   output logic      [1:0]       statusByteOther,
   output logic      [1:0]       statusByteOcFault,
   output logic      [1:0]       statusWordVout,
   output logic      [1:0]       statusWordIout,
   output logic      [1:0]       statusVoutMinWarn,
   output logic      [1:0]       statusIoutOcWarn,
   output logic      [1:0]       statusIoutOcFault,
   output logic      [1:0]       channelRun,
   output logic                  alertPinOut,
   output logic                  alertPinOe
);
   import pmolp_pkg::*;

   // Programmable registers
   logic [1:0][7:0]  floor_reg;
   logic [1:0][10:0] faultLim_reg;
   logic [1:0][10:0] warnLim_reg;
   logic [7:0]       action_reg;
   logic             loadPend_reg;
   logic             loadNow;

   // Pin synchronisers and sticky status
   logic [1:0] pinMeta_reg;
   logic [1:0] pinSync_reg;
   logic [1:0] vminFlag_reg;
   logic [1:0] ocWarnFlag_reg;
   logic [1:0] ocFaultFlag_reg;
   logic       alert_reg;

   // Command decode
   logic [1:0] pageHit;
   logic       pageOk;
   logic       isPaged;
   logic       isByteCmd;
   logic       accessOk;
   logic [1:0] writeCh;
   logic       writeAction;

   // Per channel events
   logic [1:0] clampEvent;
   logic [1:0] warnActive;
   logic [1:0] faultEvent;
   logic [1:0] chEnabled;
   logic [1:0][10:0] faultDefault;

   // Page decode: FFh reaches both channels at once
   assign pageHit[0] = (cmdPage == PAGE_A) || (cmdPage == PAGE_ALL);
   assign pageHit[1] = (cmdPage == PAGE_B) || (cmdPage == PAGE_ALL);
   assign pageOk     = |pageHit;

   // Word commands are paged, the action byte is not
   assign isPaged   = (cmdCode == CMD_FLOOR) || (cmdCode == CMD_FAULT_LIM) ||
                      (cmdCode == CMD_WARN_LIM);
   assign isByteCmd = (cmdCode == CMD_ACTION);

   // Wrong transaction size or a bad page refuses the access
   assign accessOk = cmdValid &&
                     ((isPaged && cmdIsWord && pageOk) ||
                      (isByteCmd && !cmdIsWord));
   assign writeCh     = {2{accessOk && cmdWrite && isPaged}} & pageHit;
   assign writeAction = accessOk && cmdWrite && isByteCmd;

   // Defaults are loaded one edge after reset release or on restore
   assign loadNow = loadPend_reg || restoreDefaults;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         loadPend_reg <= 1'b1;
      else
         loadPend_reg <= 1'b0;
   end

   // Default fault limit is max plus half of max, kept at mantissa width
   genvar gc;
   generate
      for (gc = 0; gc < 2; gc++)
      begin : g_def
         logic [11:0] sum;
         assign sum = {1'b0, maxCurrentCfg[gc]} +
                      {2'b00, maxCurrentCfg[gc][10:1]};
         assign faultDefault[gc] = sum[10:0];
      end
   endgenerate

   // Floor registers; defaults win over a host write in the same cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         floor_reg <= {2{FLOOR_RST}};
      else
         for (int c = 0; c < 2; c++)
         begin
            if (loadNow)
               floor_reg[c] <= floorNvm[c];
            else if (writeCh[c] && cmdCode == CMD_FLOOR)
               floor_reg[c] <= cmdWriteData[VID_W-1:0];
         end
   end

   // Limit registers; exponent is not stored, always zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         faultLim_reg <= {2{LIMIT_RST}};
         warnLim_reg  <= {2{LIMIT_RST}};
      end
      else
         for (int c = 0; c < 2; c++)
         begin
            if (loadNow)
            begin
               faultLim_reg[c] <= faultDefault[c];
               warnLim_reg[c]  <= maxCurrentCfg[c];
            end
            else if (writeCh[c] && cmdCode == CMD_FAULT_LIM)
               faultLim_reg[c] <= cmdWriteData[MAN_MSB:0];
            else if (writeCh[c] && cmdCode == CMD_WARN_LIM)
               warnLim_reg[c] <= cmdWriteData[MAN_MSB:0];
         end
   end

   // Shared action byte
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         action_reg <= ACTION_RST;
      else if (loadNow)
         action_reg <= actionNvm;
      else if (writeAction)
         action_reg <= cmdWriteData[7:0];
   end

   // Read answer one cycle after the request; FFh reads channel A
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cmdReadData  <= 16'h0000;
         cmdReadValid <= 1'b0;
         cmdError     <= 1'b0;
      end
      else
      begin
         cmdReadValid <= accessOk && !cmdWrite;
         cmdError     <= cmdValid && !accessOk;
         if (accessOk && !cmdWrite)
         begin
            case (cmdCode)
               CMD_FLOOR:
                  cmdReadData <= {8'h00,
                                  floor_reg[pageHit[0] ? 0 : 1]};
               CMD_FAULT_LIM:
                  cmdReadData <= {LIMIT_EXP,
                                  faultLim_reg[pageHit[0] ? 0 : 1]};
               CMD_WARN_LIM:
                  cmdReadData <= {LIMIT_EXP,
                                  warnLim_reg[pageHit[0] ? 0 : 1]};
               CMD_ACTION:
                  cmdReadData <= {8'h00, action_reg};
               default:
                  cmdReadData <= 16'h0000;
            endcase
         end
      end
   end

   // Enable pins arrive from outside, two stages before use
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pinMeta_reg <= 2'b00;
         pinSync_reg <= 2'b00;
      end
      else
      begin
         pinMeta_reg <= channelEnablePins;
         pinSync_reg <= pinMeta_reg;
      end
   end

   // Enable is the AND of the sources that the configuration selects
   assign chEnabled =
      ({2{!onOffConfig[ONOFF_PIN_BIT]}} | pinSync_reg) &
      ({2{!onOffConfig[ONOFF_OP_BIT]}} | operationOn);

   // Voltage command clamp; a raised floor also pulls the command up
   always_comb
   begin
      for (int c = 0; c < 2; c++)
         clampEvent[c] = (voutRequestValid[c] &&
                          voutRequest[c] < floor_reg[c]) ||
                         (voutCommand[c] < floor_reg[c]);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         voutCommand <= {2{VOUT_RST}};
      else
         for (int c = 0; c < 2; c++)
         begin
            if (clampEvent[c])
               voutCommand[c] <= floor_reg[c];
            else if (voutRequestValid[c])
               voutCommand[c] <= voutRequest[c];
         end
   end

   // Protection channels, each shuts down only itself
   generate
      for (gc = 0; gc < 2; gc++)
      begin : g_ch
         pmolp_channel
         #(
            .RetryCycles (RetryCycles)
         )
         u_channel
         (
            .mclk          (mclk),
            .rst           (rst),
            .enabled       (chEnabled[gc]),
            .outputCurrent (outputCurrent[gc]),
            .faultLimit    (faultLim_reg[gc]),
            .warnLimit     (warnLim_reg[gc]),
            .actionCode    (action_reg),
            .running       (channelRun[gc]),
            .warnActive    (warnActive[gc]),
            .faultEvent    (faultEvent[gc])
         );
      end
   endgenerate

   // Sticky flags; a new event wins over clear-faults in the same cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         vminFlag_reg    <= 2'b00;
         ocWarnFlag_reg  <= 2'b00;
         ocFaultFlag_reg <= 2'b00;
      end
      else
      begin
         vminFlag_reg    <= clampEvent |
                            (vminFlag_reg & {2{!clearFaults}});
         // Limits still hold zero in the load cycle, so no warning then
         ocWarnFlag_reg  <= (warnActive & {2{!loadPend_reg}}) |
                            (ocWarnFlag_reg & {2{!clearFaults}});
         ocFaultFlag_reg <= faultEvent |
                            (ocFaultFlag_reg & {2{!clearFaults}});
      end
   end

   // Summary status bits derived from the sticky flags
   assign statusVoutMinWarn = vminFlag_reg;
   assign statusIoutOcWarn  = ocWarnFlag_reg;
   assign statusIoutOcFault = ocFaultFlag_reg;
   assign statusByteOther   = vminFlag_reg | ocWarnFlag_reg;
   assign statusByteOcFault = ocFaultFlag_reg;
   assign statusWordVout    = vminFlag_reg;
   assign statusWordIout    = ocWarnFlag_reg | ocFaultFlag_reg;

   // Alert follows unmasked flags; released once all are cleared
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         alert_reg <= 1'b0;
      else
         alert_reg <= (|vminFlag_reg && !alertMask[MASK_VMIN]) ||
                      (|ocWarnFlag_reg && !alertMask[MASK_OCWARN]) ||
                      (|ocFaultFlag_reg &&
                       !alertMask[MASK_OCFAULT]);
   end

   // Open-drain alert: pull low while asserted, otherwise released
   assign alertPinOut = 1'b0;
   assign alertPinOe  = alert_reg;

endmodule

//--- verification/pmolp_checker.sv
// Port-level assertions for the output limit and protection block
`timescale 1ns/10ps
module pmolp_checker
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       cmdValid,
   input wire logic       cmdWrite,
   input wire logic       cmdReadValid,
   input wire logic       cmdError,
   input wire logic       clearFaults,
   input wire logic [2:0] alertMask,
   input wire logic [1:0] statusByteOther,
   input wire logic [1:0] statusByteOcFault,
   input wire logic [1:0] statusWordVout,
   input wire logic [1:0] statusWordIout,
   input wire logic [1:0] statusVoutMinWarn,
   input wire logic [1:0] statusIoutOcWarn,
   input wire logic [1:0] statusIoutOcFault,
   input wire logic [1:0] channelRun,
   input wire logic       alertPinOe
);
   logic [5:0] sticky;
   logic       anyCause;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // Alert is registered from the flags, so it trails them by one cycle
   assign sticky = {statusVoutMinWarn, statusIoutOcWarn, statusIoutOcFault};
   assign anyCause = (|statusVoutMinWarn && !alertMask[0])
                   || (|statusIoutOcWarn && !alertMask[1])
                   || (|statusIoutOcFault && !alertMask[2]);

   a_read_answer: assert property (
      cmdValid && !cmdWrite |=> cmdReadValid != cmdError)
      else $error("read without exactly one answer");
   a_floor_status: assert property (
      (statusVoutMinWarn & ~(statusByteOther & statusWordVout)) == 2'h0)
      else $error("floor warning without summary bits");
   a_floor_alert: assert property (
      |statusVoutMinWarn && !alertMask[0] |=> alertPinOe)
      else $error("floor warning did not raise alert");
   a_warn_status: assert property (
      (statusIoutOcWarn & ~(statusByteOther & statusWordIout)) == 2'h0)
      else $error("current warning without summary bits");
   a_warn_alert: assert property (
      |statusIoutOcWarn && !alertMask[1] |=> alertPinOe)
      else $error("current warning did not raise alert");
   a_fault_status: assert property (
      (statusIoutOcFault & ~(statusByteOcFault & statusWordIout)) == 2'h0)
      else $error("current fault without summary bits");
   a_fault_alert: assert property (
      |statusIoutOcFault && !alertMask[2] |=> alertPinOe)
      else $error("current fault did not raise alert");
   a_fault_stop: assert property (
      (statusIoutOcFault & ~$past(statusIoutOcFault) & channelRun) == 2'h0)
      else $error("channel kept running at a new fault");
   a_alert_release: assert property (
      !anyCause |=> !alertPinOe)
      else $error("alert held without an unmasked cause");
   a_flags_sticky: assert property (
      !$past(clearFaults) |-> (~sticky & $past(sticky)) == 6'h00)
      else $error("status flag dropped without clear");

   c_refused: cover property (cmdError);
   c_alert: cover property ($rose(alertPinOe));
   c_retry: cover property ($fell(channelRun[1]));
endmodule

bind pmolp_top pmolp_checker u_chk (.mclk, .rst, .cmdValid, .cmdWrite,
   .cmdReadValid, .cmdError, .clearFaults, .alertMask, .statusByteOther,
   .statusByteOcFault, .statusWordVout, .statusWordIout, .statusVoutMinWarn,
   .statusIoutOcWarn, .statusIoutOcFault, .channelRun, .alertPinOe);

//--- verification/pmolp_host.sv
// Management bus host stand-in issuing decoded command transactions
`timescale 1ns/10ps
module pmolp_host
(
   input  wire logic        mclk,
   input  wire logic [15:0] cmdReadData,
   input  wire logic        cmdReadValid,
   input  wire logic        cmdError,
   output logic             cmdValid,
   output logic             cmdWrite,
   output logic             cmdIsWord,
   output logic      [7:0]  cmdCode,
   output logic      [7:0]  cmdPage,
   output logic      [15:0] cmdWriteData
);
   // Idle bus at time zero
   initial
   begin
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdIsWord = 1'b0;
      cmdCode = 8'h00;
      cmdPage = 8'h00;
      cmdWriteData = 16'h0000;
   end

   // One transfer; size and page come from the caller
   task automatic xfer(input logic w, word, input logic [7:0] c, p,
                       input logic [15:0] d, output logic [15:0] rd,
                       output logic err);
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdIsWord <= word;
      cmdCode <= c;
      cmdPage <= p;
      cmdWriteData <= d;
      @(posedge mclk);
      cmdValid <= 1'b0;
      cmdWriteData <= ~d; // Released data must not look stable
      #1;
      rd = cmdReadData;
      err = cmdError;
   endtask
endmodule

//--- verification/tb.sv
// Scenario bench for the output limit and protection block
`timescale 1ns/10ps
module tb;
   import pmolp_pkg::*;
   localparam int unsigned TestRetry = 8;
   logic             mclk = 1'b0;
   logic             rst = 1'b1;
   logic             clearFaults = 1'b0;
   logic             restoreDefaults = 1'b0;
   logic [1:0][7:0]  floorNvm = {8'h30, 8'h20};
   logic [7:0]       actionNvm = ACT_LATCH;
   logic [1:0][10:0] maxCurrentCfg = {11'h03C, 11'h0B4};
   logic [1:0][10:0] outputCurrent = '0;
   logic [1:0][7:0]  voutRequest = '0;
   logic [1:0]       voutRequestValid = 2'h0;
   logic [1:0]       channelEnablePins = 2'h3;
   logic [1:0]       operationOn = 2'h3;
   logic [1:0]       onOffConfig = 2'h1;
   logic [2:0]       alertMask = 3'h0;
   logic             cmdValid, cmdWrite, cmdIsWord, cmdReadValid, cmdError;
   logic [7:0]       cmdCode, cmdPage;
   logic [15:0]      cmdWriteData, cmdReadData;
   logic [1:0][7:0]  voutCommand;
   logic [1:0]       statusByteOther, statusByteOcFault, statusWordVout;
   logic [1:0]       statusWordIout, statusVoutMinWarn, statusIoutOcWarn;
   logic [1:0]       statusIoutOcFault, channelRun;
   logic             alertPinOe;
   int               numErrors = 0;
   int               nTests = 0;
   int               cycles = 0;

   pmolp_top #(.RetryCycles(TestRetry)) DUT (.*, .alertPinOut());
   pmolp_host host (.*);

   always #10 mclk = ~mclk;

   // Hang guard; the full run needs well under a thousand cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         numErrors++;
         results();
      end
   end

   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      nTests++;
      if (got !== exp)
      begin
         numErrors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("Checks %0d, mismatches %0d", nTests, numErrors);
      if (numErrors == 0 && nTests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Command helpers; rd and wr send only the action byte as a byte transfer, bad takes the size from the caller
   task automatic rd(input logic [7:0] c, p, input logic [15:0] e);
      logic [15:0] got;
      logic        err;
      host.xfer(1'b0, c != CMD_ACTION, c, p, 16'h0000, got, err);
      chk({err, got}, {1'b0, e});
   endtask

   task automatic wr(input logic [7:0] c, p, input logic [15:0] d);
      logic [15:0] got;
      logic        err;
      host.xfer(1'b1, c != CMD_ACTION, c, p, d, got, err);
      chk(err, 1'b0);
   endtask

   task automatic bad(input logic w, word, input logic [7:0] c, p);
      logic [15:0] got;
      logic        err;
      host.xfer(w, word, c, p, 16'h0001, got, err);
      chk(err, 1'b1);
   endtask

   task automatic clr();
      @(posedge mclk);
      clearFaults <= 1'b1;
      @(posedge mclk);
      clearFaults <= 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic req(input int c, input logic [7:0] v);
      @(posedge mclk);
      voutRequest[c] <= v;
      voutRequestValid[c] <= 1'b1;
      @(posedge mclk);
      voutRequestValid[c] <= 1'b0;
      #1;
   endtask

   task automatic checkDefaults();
      rd(CMD_FLOOR, PAGE_A, 16'h0020);
      rd(CMD_FLOOR, PAGE_B, 16'h0030);
      rd(CMD_FAULT_LIM, PAGE_A, 16'h010E);
      rd(CMD_FAULT_LIM, PAGE_B, 16'h005A);
      rd(CMD_WARN_LIM, PAGE_A, 16'h00B4);
      rd(CMD_WARN_LIM, PAGE_B, 16'h003C);
      rd(CMD_ACTION, PAGE_B, 16'h00C0);
   endtask

   task automatic checkAccess();
      wr(CMD_FLOOR, PAGE_ALL, 16'hFF40);
      rd(CMD_FLOOR, PAGE_A, 16'h0040);
      rd(CMD_FLOOR, PAGE_B, 16'h0040);
      wr(CMD_WARN_LIM, PAGE_B, 16'hF87F);
      rd(CMD_WARN_LIM, PAGE_B, 16'h007F);
      rd(CMD_WARN_LIM, PAGE_A, 16'h00B4);
      bad(1'b1, 1'b1, CMD_FAULT_LIM, 8'h02);
      bad(1'b0, 1'b0, CMD_FLOOR, PAGE_A);
      bad(1'b1, 1'b1, CMD_ACTION, PAGE_A);
      wr(CMD_ACTION, PAGE_B, 16'h00FA);
      rd(CMD_ACTION, PAGE_A, 16'h00FA);
      wr(CMD_ACTION, PAGE_ALL, 16'h00C0);
   endtask

   task automatic checkClamp();
      clr();
      req(0, 8'h3F);
      chk(voutCommand[0], 8'h40);
      chk({statusVoutMinWarn[0], statusWordVout[0]}, 2'h3);
      @(posedge mclk);
      #1 chk(alertPinOe, 1'b1);
      req(1, 8'h41);
      chk({voutCommand[1], statusVoutMinWarn[1]}, 9'h082);
      req(1, 8'h10);
      chk(voutCommand[1], 8'h40);
      clr();
      chk({statusVoutMinWarn[0], alertPinOe}, 2'h0);
      @(posedge mclk);
      alertMask <= 3'h1;
      req(0, 8'h00);
      @(posedge mclk);
      #1 chk({voutCommand[0], alertPinOe}, 9'h080);
      @(posedge mclk);
      alertMask <= 3'h0;
      clr();
   endtask

   // Latch-off released once by the pin, once by the operation bit
   task automatic checkLatch();
      wr(CMD_FAULT_LIM, PAGE_A, 16'h0064);
      wr(CMD_WARN_LIM, PAGE_A, 16'h0032);
      for (int s = 0; s < 2; s++)
      begin
         @(posedge mclk);
         onOffConfig <= s ? 2'h2 : 2'h1;
         outputCurrent[0] <= 11'd50;
         @(posedge mclk);
         #1 chk({statusIoutOcWarn[0], statusWordIout[0]}, 2'h3);
         chk(channelRun, 2'h3);
         @(posedge mclk);
         outputCurrent[0] <= 11'd100;
         @(posedge mclk);
         #1 chk({statusIoutOcFault[0], statusByteOcFault[0]}, 2'h3);
         chk(channelRun, 2'h2);
         @(posedge mclk);
         outputCurrent[0] <= 11'd0;
         clr();
         repeat (10) @(posedge mclk);
         #1 chk(channelRun[0], 1'b0);
         @(posedge mclk);
         {operationOn[0], channelEnablePins[0]} <= s ? 2'b01 : 2'b10;
         repeat (4) @(posedge mclk);
         {operationOn[0], channelEnablePins[0]} <= 2'b11;
         repeat (4) @(posedge mclk);
         #1 chk(channelRun[0], 1'b1);
      end
   endtask

   task automatic checkRetry();
      wr(CMD_ACTION, PAGE_B, 16'h00FA);
      @(posedge mclk);
      outputCurrent[1] <= 11'h05A;
      @(posedge mclk);
      outputCurrent[1] <= 11'h000;
      #1 chk(channelRun, 2'h1);
      // Restart lands exactly one retry period after the fault edge
      repeat (TestRetry - 1) @(posedge mclk);
      #1 chk(channelRun[1], 1'b0);
      @(posedge mclk);
      #1 chk(channelRun[1], 1'b1);
      clr();
   endtask

   task automatic checkRestore();
      wr(CMD_WARN_LIM, PAGE_ALL, 16'h0010);
      @(posedge mclk);
      restoreDefaults <= 1'b1;
      @(posedge mclk);
      restoreDefaults <= 1'b0;
      rd(CMD_WARN_LIM, PAGE_B, 16'h003C);
      rd(CMD_FAULT_LIM, PAGE_A, 16'h010E);
      wr(CMD_FAULT_LIM, PAGE_A, 16'h0050);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      rd(CMD_FAULT_LIM, PAGE_A, 16'h010E);
      rd(CMD_WARN_LIM, PAGE_A, 16'h00B4);
      chk(statusIoutOcWarn, 2'h0);
   endtask

   // Main sequence: reset, then each scenario in turn
   initial
   begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      checkDefaults();
      checkAccess();
      checkClamp();
      checkLatch();
      checkRetry();
      checkRestore();
      results();
   end
endmodule
